//--- rtl/adc_seq_defs.svh
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH
// Register byte offsets
`define OFS_SC_ONE      8'h00
`define OFS_SC_TWO      8'h04
`define OFS_RES_HIGH    8'h08
`define OFS_RES_LOW     8'h0C
`define OFS_CONFIG      8'h10
`define OFS_CMP_HIGH    8'h14
`define OFS_CMP_LOW     8'h18
// Field positions and field values
`define SC1_CONT_BIT    5
`define SC1_IEN_BIT     6
`define SC1_DONE_BIT    7
`define SC2_HWT_BIT     0
`define SC2_CMPE_BIT    1
`define SC2_CMPGT_BIT   2
`define SC2_ACT_BIT     7
`define CFG_MODE_10     2'h2
`define CHAN_OFF        5'h1F
`define SRC_ASYNC       2'h3
// Reset values
`define SC1_RESET       8'h1F
`define CFG_RESET       8'h00
// Timing in conversion clock cycles; FINISH_BUS in bus cycles
`define SETUP_CYC       9'h003
`define SAMPLE_SHORT    9'h004
`define SAMPLE_LONG     9'h018
`define CONV_8BIT       9'h00D
`define CONV_10BIT      9'h010
`define FINISH_BUS      9'h005
// Asynchronous clock start-up, ns and 100 MHz bus cycles
`define STARTUP_NS      5000
`define CLK_NS          10
`define STARTUP_CYC     9'((`STARTUP_NS + `CLK_NS - 1) / `CLK_NS)
`endif

//--- rtl/adc_seq_pkg.sv
`default_nettype none
package adc_seq_pkg;
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_STARTUP = 3'b001,
    ST_SETUP   = 3'b010,
    ST_SAMPLE  = 3'b011,
    ST_CONV    = 3'b100,
    ST_FINISH  = 3'b101,
    ST_XFER    = 3'b110
  } seq_state_type;
endpackage : adc_seq_pkg
`default_nettype wire

//--- rtl/adc_conversion_sequencer.sv
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`include "adc_seq_defs.svh"
`default_nettype none
// Summary of operation
// - Hardware trigger rising edge starts a conversion
// - Trigger edges ignored while converting
// - Continuous hardware mode: only first edge counts
// - Resolution field picks 10-bit or 8-bit
// - Software mode: control-one write starts conversion
// - Continuous mode restarts after each transfer
// - Transfer sets done flag and interrupt
// - High byte read in 10-bit mode locks out new results
// - Single compare-false conversion ends despite lock
// - Other blocked transfers start another conversion
// - Control-one write aborts, then maybe restarts
// - Other control writes abort conversion
// - Reset or stop without async clock aborts
// - Non-reset aborts keep result registers
// - Reset clears result registers
// - Idle until started; async clock only active
// - Sample, then approximate, then transfer
// - Short sample first conversion cycle budget
// - Long sample first conversion cycle budget
// - Async source adds start-up delay
// - Later continuous conversions drop fixed overhead
// - Disabled in reset or channel all ones
// - Conversion clock divided by 1, 2, 4, 8
module adc_conversion_sequencer (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Trigger, clock sources and mode inputs
  input  wire logic        hw_trigger_in,
  input  wire logic        alt_clk_tick,
  input  wire logic        async_clk_tick,
  input  wire logic        stop_mode,
  // Analog converter side
  input  wire logic [9:0]  sar_result,
  output var  logic        sample_active,
  output var  logic        convert_active,
  output var  logic        async_clk_enable,
  output var  logic [4:0]  channel_select,
  output var  logic        done_irq
);
  import adc_seq_pkg::*;

  // ----------------------------------------------------------------
  // Reset synchroniser and registers
  // ----------------------------------------------------------------
  logic        rst_m_r, rst_s_n;
  logic [7:0]  sc1_r, sc2_r, cfg_r, cvh_r, cvl_r;
  logic        done_r, lock_r, first_r;
  logic [9:0]  result_r;
  logic [2:0]  trig_r;
  logic        half_r;
  logic [2:0]  div_r;
  logic [8:0]  cnt_r, cnt_nxt;
  seq_state_type state_r, state_nxt;
  logic        aw_got_r, w_got_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic        w_lane0_r;

  // Release reset through two flip-flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_r <= 1'b0;
      rst_s_n <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_s_n <= rst_m_r;
    end
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire wr_go    = aw_got_r && w_got_r && !s_axi_bvalid;
  wire wr_en    = wr_go && w_lane0_r;
  wire [7:0] wd = w_data_r[7:0];
  wire wr_sc1   = wr_en && aw_addr_r == `OFS_SC_ONE;
  wire wr_other = wr_en && (aw_addr_r == `OFS_SC_TWO ||
                  aw_addr_r == `OFS_CONFIG || aw_addr_r == `OFS_CMP_HIGH ||
                  aw_addr_r == `OFS_CMP_LOW);
  wire wr_known = wr_sc1 || wr_other || aw_addr_r == `OFS_RES_HIGH ||
                  aw_addr_r == `OFS_RES_LOW;
  wire rd_go    = s_axi_arvalid && s_axi_arready;
  wire rd_high  = rd_go && s_axi_araddr == `OFS_RES_HIGH;
  wire rd_low   = rd_go && s_axi_araddr == `OFS_RES_LOW;

  // ----------------------------------------------------------------
  // Control decode
  // ----------------------------------------------------------------
  wire mode_10   = cfg_r[3:2] == `CFG_MODE_10;
  wire [1:0] src = cfg_r[1:0];
  wire long_smp  = cfg_r[4];
  wire [1:0] div = cfg_r[6:5];
  wire hw_mode   = sc2_r[`SC2_HWT_BIT];
  wire cont      = sc1_r[`SC1_CONT_BIT];
  wire chan_off  = sc1_r[4:0] == `CHAN_OFF;
  wire idle      = state_r == ST_IDLE;
  wire stop_abt  = stop_mode && src != `SRC_ASYNC;
  wire trig_rise = trig_r[1] && !trig_r[2];
  wire hw_start  = hw_mode && trig_rise && idle;
  wire sw_start  = wr_sc1 && !hw_mode && wd[4:0] != `CHAN_OFF;
  wire abort     = wr_sc1 || wr_other || stop_abt || chan_off;
  // Conversion clock source and divider
  wire src_tick  = src == 2'h0 ? 1'b1 : src == 2'h1 ? half_r :
                   src == 2'h2 ? alt_clk_tick : async_clk_tick;
  wire [2:0] dmask = 3'((4'h1 << div) - 4'h1);
  wire conversion_clock      = src_tick && (div_r & dmask) == dmask;
  // Compare and transfer decisions
  wire [9:0] cmp_val = mode_10 ? {cvh_r[1:0], cvl_r} : {2'h0, cvl_r};
  wire [9:0] res_in  = mode_10 ? sar_result : {2'h0, sar_result[7:0]};
  wire cmp_true  = sc2_r[`SC2_CMPGT_BIT] ? res_in >= cmp_val :
                                           res_in < cmp_val;
  wire cmp_fail  = sc2_r[`SC2_CMPE_BIT] && !cmp_true;
  wire in_xfer   = state_r == ST_XFER;
  wire blocked   = in_xfer && lock_r && mode_10;
  wire xfer_ok   = in_xfer && !blocked && !cmp_fail && !abort;
  wire end_op    = in_xfer && !cont && cmp_fail;
  wire [8:0] smp_len  = long_smp ? `SAMPLE_LONG : `SAMPLE_SHORT;
  wire [8:0] conv_len = mode_10 ? `CONV_10BIT : `CONV_8BIT;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Next state: startup, setup, sample, approximate, finish, transfer
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    unique case (state_r)
      ST_IDLE: begin
        cnt_nxt = 9'h000;
      end
      ST_STARTUP: begin
        cnt_nxt = cnt_r + 9'h001;
        if (cnt_r == `STARTUP_CYC - 9'h001) begin
          state_nxt = ST_SETUP;
          cnt_nxt   = 9'h000;
        end
      end
      ST_SETUP: begin
        if (conversion_clock) begin
          cnt_nxt = cnt_r + 9'h001;
          if (cnt_r == `SETUP_CYC - 9'h001) begin
            state_nxt = ST_SAMPLE;
            cnt_nxt   = 9'h000;
          end
        end
      end
      ST_SAMPLE: begin
        if (conversion_clock) begin
          cnt_nxt = cnt_r + 9'h001;
          if (cnt_r == smp_len - 9'h001) begin
            state_nxt = ST_CONV;
            cnt_nxt   = 9'h000;
          end
        end
      end
      ST_CONV: begin
        if (conversion_clock) begin
          cnt_nxt = cnt_r + 9'h001;
          if (cnt_r == conv_len - 9'h001) begin
            state_nxt = first_r ? ST_FINISH : ST_XFER;
            cnt_nxt   = 9'h000;
          end
        end
      end
      ST_FINISH: begin
        cnt_nxt = cnt_r + 9'h001;
        if (cnt_r == `FINISH_BUS - 9'h002) begin
          state_nxt = ST_XFER;
        end
      end
      ST_XFER: begin
        cnt_nxt = 9'h000;
        if (end_op || (!cont && !blocked)) begin
          state_nxt = ST_IDLE;
        end else begin
          state_nxt = ST_SAMPLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        cnt_nxt   = 9'h000;
      end
    endcase
    if (abort) begin
      state_nxt = ST_IDLE;
      cnt_nxt   = 9'h000;
    end
    if ((sw_start || hw_start) && !stop_abt) begin
      state_nxt = src == `SRC_ASYNC ? ST_STARTUP : ST_SETUP;
      cnt_nxt   = 9'h000;
    end
    if (chan_off && !sw_start) begin
      state_nxt = ST_IDLE;
    end
  end

  // State, counter and clock divider
  always_ff @(posedge sys_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      state_r <= ST_IDLE;
      cnt_r   <= 9'h000;
      first_r <= 1'b0;
      half_r  <= 1'b0;
      div_r   <= 3'h0;
      trig_r  <= 3'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      first_r <= state_nxt == ST_STARTUP || state_nxt == ST_SETUP ||
                 (first_r && !in_xfer && state_nxt != ST_IDLE);
      half_r  <= !half_r;
      div_r   <= idle ? 3'h0 : (src_tick ? div_r + 3'h1 : div_r);
      trig_r  <= {trig_r[1:0], hw_trigger_in};
    end
  end

  // ----------------------------------------------------------------
  // Result, flag and read lock
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      result_r <= 10'h000;
      done_r   <= 1'b0;
      lock_r   <= 1'b0;
    end else begin
      if (xfer_ok) begin
        result_r <= res_in;
      end
      done_r <= xfer_ok || (done_r && !wr_sc1 && !rd_low);
      lock_r <= (rd_high && mode_10) || (lock_r && !rd_low);
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      sc1_r <= `SC1_RESET;
      sc2_r <= 8'h00;
      cfg_r <= `CFG_RESET;
      cvh_r <= 8'h00;
      cvl_r <= 8'h00;
    end else if (wr_en) begin
      if (wr_sc1) sc1_r <= {1'b0, wd[6:0]};
      if (aw_addr_r == `OFS_SC_TWO) sc2_r <= {5'h00, wd[2:0]};
      if (aw_addr_r == `OFS_CONFIG) cfg_r <= wd;
      if (aw_addr_r == `OFS_CMP_HIGH) cvh_r <= {6'h00, wd[1:0]};
      if (aw_addr_r == `OFS_CMP_LOW) cvl_r <= wd;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  wire [7:0] rd_mux =
    s_axi_araddr == `OFS_SC_ONE   ? {done_r, sc1_r[6:0]} :
    s_axi_araddr == `OFS_SC_TWO   ? {!idle, 4'h0, sc2_r[2:0]} :
    s_axi_araddr == `OFS_RES_HIGH ? {6'h00, result_r[9:8]} :
    s_axi_araddr == `OFS_RES_LOW  ? result_r[7:0] :
    s_axi_araddr == `OFS_CONFIG   ? cfg_r :
    s_axi_araddr == `OFS_CMP_HIGH ? cvh_r :
    s_axi_araddr == `OFS_CMP_LOW  ? cvl_r : 8'h00;
  wire rd_known = s_axi_araddr <= `OFS_CMP_LOW &&
                  s_axi_araddr[1:0] == 2'h0;

  // Write address and data capture, then response
  always_ff @(posedge sys_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      aw_got_r     <= 1'b0;
      w_got_r      <= 1'b0;
      aw_addr_r    <= 8'h00;
      w_data_r     <= 32'h0000_0000;
      w_lane0_r    <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r   <= 1'b1;
        w_data_r  <= s_axi_wdata;
        w_lane0_r <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read response and registered outputs
  always_ff @(posedge sys_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      s_axi_rvalid     <= 1'b0;
      s_axi_rdata      <= 32'h0000_0000;
      s_axi_rresp      <= 2'h0;
      sample_active    <= 1'b0;
      convert_active   <= 1'b0;
      async_clk_enable <= 1'b0;
      done_irq         <= 1'b0;
    end else begin
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_mux};
        s_axi_rresp  <= rd_known ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      sample_active    <= state_nxt == ST_SAMPLE;
      convert_active   <= state_nxt == ST_CONV;
      async_clk_enable <= state_nxt != ST_IDLE &&
                          src == `SRC_ASYNC;
      done_irq <= (xfer_ok || (done_r && !wr_sc1 && !rd_low)) &&
                  sc1_r[`SC1_IEN_BIT];
    end
  end

  assign s_axi_awready  = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready   = !w_got_r && !s_axi_bvalid;
  assign s_axi_arready  = !s_axi_rvalid;
  assign channel_select = sc1_r[4:0];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  wire quiet = !wr_en && !stop_abt && !chan_off;

  property p_trig_start;
    @(posedge sys_clk) disable iff (!rst_s_n)
    hw_mode && trig_rise && idle && quiet |=> !idle;
  endproperty
  a_trig_start: assert property (p_trig_start)
    else $error("trigger edge did not start a conversion");

  property p_trig_ignored;
    @(posedge sys_clk) disable iff (!rst_s_n)
    state_r == ST_CONV && trig_rise && quiet |=>
      state_r != ST_SETUP && state_r != ST_STARTUP;
  endproperty
  a_trig_ignored: assert property (p_trig_ignored)
    else $error("trigger edge restarted a running conversion");

  property p_done_set;
    @(posedge sys_clk) disable iff (!rst_s_n)
    xfer_ok |=> done_r && result_r == $past(res_in);
  endproperty
  a_done_set: assert property (p_done_set)
    else $error("transfer did not set flag and result");

  property p_block;
    @(posedge sys_clk) disable iff (!rst_s_n)
    blocked |=> $stable(result_r) &&
      done_r == $past(done_r && !rd_low && !wr_sc1);
  endproperty
  a_block: assert property (p_block)
    else $error("blocked transfer changed result or flag");

  property p_block_retry;
    @(posedge sys_clk) disable iff (!rst_s_n)
    blocked && !end_op && !abort && quiet |=> state_r == ST_SAMPLE;
  endproperty
  a_block_retry: assert property (p_block_retry)
    else $error("blocked transfer did not restart");

  property p_other_abort;
    @(posedge sys_clk) disable iff (!rst_s_n)
    wr_other && !idle |=> idle;
  endproperty
  a_other_abort: assert property (p_other_abort)
    else $error("control write did not abort");

  property p_abort_keep;
    @(posedge sys_clk) disable iff (!rst_s_n)
    abort |=> $stable(result_r);
  endproperty
  a_abort_keep: assert property (p_abort_keep)
    else $error("abort altered the result");

  property p_chan_off;
    @(posedge sys_clk) disable iff (!rst_s_n)
    chan_off && !sw_start |=> idle;
  endproperty
  a_chan_off: assert property (p_chan_off)
    else $error("converter ran with channel all ones");

  property p_async_en;
    @(posedge sys_clk) disable iff (!rst_s_n)
    async_clk_enable |-> !idle && src == `SRC_ASYNC;
  endproperty
  a_async_en: assert property (p_async_en)
    else $error("async clock enabled while idle");
endmodule : adc_conversion_sequencer
`default_nettype wire

//--- tb/adc_far_side.sv
`default_nettype none
module adc_far_side (
  // Clock and bench control
  input  wire logic       sys_clk,
  input  wire logic [9:0] level,
  input  wire logic       fire,
  // Converter and trigger side
  input  wire logic       sample_active,
  input  wire logic       convert_active,
  output var  logic [9:0] sar_result,
  output var  logic       hw_trigger_in,
  output var  logic       alt_clk_tick,
  output var  logic       async_clk_tick
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0] hold_r;
  logic [1:0] div_r;
  logic       half_r;

  initial begin
    hold_r = 3'h0;
    div_r = 2'h0;
    half_r = 1'b0;
    hw_trigger_in = 1'b0;
  end

  // Result hold window, alternate tick every 3rd cycle, async every 2nd
  always @(posedge sys_clk) begin
    hold_r <= convert_active ? 3'h7 : hold_r - {2'h0, hold_r != 3'h0};
    div_r <= (div_r == 2'h2) ? 2'h0 : div_r + 2'h1;
    half_r <= ~half_r;
  end

  // Outside a conversion the result lines show the inverse, not stale data
  assign sar_result = (sample_active | convert_active | (hold_r != 3'h0))
                    ? level : ~level;
  assign alt_clk_tick = (div_r == 2'h0);
  assign async_clk_tick = half_r;

  // Trigger edge lands off the clock edge and is held several cycles
  always @(posedge fire) begin
    #3 hw_trigger_in = 1'b1;
    #40 hw_trigger_in = 1'b0;
  end
endmodule : adc_far_side
`default_nettype wire

//--- tb/adc_conversion_sequencer_tb.sv
`include "adc_seq_defs.svh"
`default_nettype none
`define CHK(g, e) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("mismatch at %0t: got %h expected %h", $time, g, e); \
  end \
end
module adc_conversion_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        sys_clk, rst_n, stop_mode, fire, clr, samp_q;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready;
  logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        hw_trigger_in, alt_clk_tick, async_clk_tick, done_irq;
  logic        sample_active, convert_active, async_clk_enable;
  logic [9:0]  sar_result, level;
  logic [4:0]  channel_select;
  logic        saw_samp, saw_async, early_conv;
  int          num_errors, n_tests, cyc, n_starts, t_prev, t_last, c, lo;
  logic [7:0]  cfg_t [7] = '{8'h00, 8'h20, 8'h40, 8'h60, 8'h18, 8'h02, 8'h0B};
  int          tick_t [7] = '{20, 20, 20, 20, 43, 20, 23};
  int          per_t [7] = '{1, 2, 4, 8, 1, 3, 2};

  adc_conversion_sequencer DUT (
    .sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .hw_trigger_in, .alt_clk_tick,
    .async_clk_tick, .stop_mode, .sar_result, .sample_active,
    .convert_active, .async_clk_enable, .channel_select, .done_irq
  );

  adc_far_side far (
    .sys_clk, .level, .fire, .sample_active, .convert_active,
    .sar_result, .hw_trigger_in, .alt_clk_tick, .async_clk_tick
  );

  // ----------------------------------------------------------------
  // Clock, monitor and watchdog
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Counts sample starts and notes phase order and async clock use
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    samp_q <= sample_active;
    if (clr) begin
      n_starts <= 0;
      saw_samp <= 1'b0;
      saw_async <= 1'b0;
      early_conv <= 1'b0;
    end else begin
      if (sample_active && !samp_q) begin
        n_starts <= n_starts + 1;
        t_prev <= t_last;
        t_last <= cyc;
      end
      saw_samp <= saw_samp | sample_active;
      saw_async <= saw_async | async_clk_enable;
      early_conv <= early_conv | (convert_active & ~saw_samp);
    end
  end

  initial begin
    repeat (60000) @(posedge sys_clk);
    num_errors++;
    wrap_up;
  end

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, 2'h0)
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [7:0] e,
                      input logic [1:0] er = 2'h0);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rdata[7:0], e)
    `CHK(s_axi_rresp, er)
  endtask : rchk

  task automatic clear_mon;
    @(posedge sys_clk);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
  endtask : clear_mon

  task automatic wait_irq(output int n);
    n = 0;
    while (done_irq !== 1'b1 && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
  endtask : wait_irq

  task automatic idle_chk;
    clear_mon;
    repeat (80) @(posedge sys_clk);
    `CHK({saw_samp, convert_active, done_irq}, 3'b000)
  endtask : idle_chk

  task automatic pulse;
    @(posedge sys_clk);
    fire <= 1'b1;
    @(posedge sys_clk);
    fire <= 1'b0;
  endtask : pulse

  task automatic wrap_up;
    $display("Counts: %0d compares, %0d mismatches", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {rst_n, stop_mode, fire, clr, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    level = 10'h0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rchk(`OFS_SC_ONE, `SC1_RESET);
    rchk(`OFS_RES_HIGH, 8'h00);
    rchk(8'h1C, 8'h00, 2'h2);
    idle_chk;
    $display("reset test done");
    // Clock sources 0, 2 and 3, every divider, resolution and sample length
    for (int i = 0; i < 7; i++) begin
      lo = tick_t[i] * per_t[i] + ((cfg_t[i][1:0] == `SRC_ASYNC) ? 500 : 0);
      level <= 10'h2C0 + 10'(i);
      wr(`OFS_CONFIG, cfg_t[i]);
      clear_mon;
      wr(`OFS_SC_ONE, 8'h43);
      wait_irq(c);
      `CHK(c >= lo && c <= lo + 2 * per_t[i] + 10, 1'b1)
      `CHK(saw_async, cfg_t[i][1:0] == `SRC_ASYNC)
      `CHK({early_conv, saw_samp, async_clk_enable}, 3'b010)
      rchk(`OFS_SC_ONE, 8'hC3);
      rchk(`OFS_RES_HIGH, (cfg_t[i][3:2] == `CFG_MODE_10) ? 8'h02 : 8'h00);
      rchk(`OFS_RES_LOW, 8'hC0 + 8'(i));
    end
    $display("timing test done");
    // Split read of the high byte blocks the next transfer
    wr(`OFS_CONFIG, 8'h08);
    level <= 10'h1E7;
    wr(`OFS_SC_ONE, 8'h43);
    wait_irq(c);
    rchk(`OFS_RES_HIGH, 8'h01);
    level <= 10'h31A;
    clear_mon;
    wr(`OFS_SC_ONE, 8'h43);
    repeat (90) @(posedge sys_clk);
    `CHK(done_irq, 1'b0)
    `CHK(n_starts >= 2, 1'b1)
    rchk(`OFS_RES_LOW, 8'hE7);
    wait_irq(c);
    rchk(`OFS_RES_HIGH, 8'h03);
    rchk(`OFS_RES_LOW, 8'h1A);
    $display("blocking test done");
    // Aborts by compare-low write, stop entry and channel-off write
    for (int k = 0; k < 3; k++) begin
      level <= 10'h0F0;
      wr(`OFS_SC_ONE, 8'h43);
      repeat (8) @(posedge sys_clk);
      if (k == 0) wr(`OFS_CMP_LOW, 8'h12);
      if (k == 1) stop_mode <= 1'b1;
      if (k == 2) wr(`OFS_SC_ONE, 8'h1F);
      repeat (3) @(posedge sys_clk);
      stop_mode <= 1'b0;
      idle_chk;
      rchk(`OFS_RES_HIGH, 8'h03);
      rchk(`OFS_RES_LOW, 8'h1A);
    end
    `CHK(channel_select, `CHAN_OFF)
    $display("abort test done");
    // Hardware trigger: single edge, repeated edge, continuous launch
    wr(`OFS_SC_TWO, 8'h01);
    wr(`OFS_SC_ONE, 8'h43);
    idle_chk;
    clear_mon;
    pulse;
    repeat (4) @(posedge sys_clk);
    pulse;
    wait_irq(c);
    `CHK(n_starts, 1)
    wr(`OFS_SC_ONE, 8'h63);
    clear_mon;
    pulse;
    repeat (100) @(posedge sys_clk);
    pulse;
    repeat (60) @(posedge sys_clk);
    `CHK(t_last - t_prev >= 20 && t_last - t_prev <= 22, 1'b1)
    `CHK(n_starts >= 6 && done_irq === 1'b1, 1'b1)
    wr(`OFS_SC_TWO, 8'h00);
    rchk(`OFS_RES_LOW, 8'hF0);
    idle_chk;
    $display("trigger test done");
    // Reset in mid-run clears the results
    level <= 10'h3FF;
    wr(`OFS_SC_ONE, 8'h03);
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rchk(`OFS_RES_HIGH, 8'h00);
    rchk(`OFS_RES_LOW, 8'h00);
    `CHK(channel_select, `CHAN_OFF)
    $display("reset abort test done");
    wrap_up;
  end
endmodule : adc_conversion_sequencer_tb
`default_nettype wire
